// *** verilog/smr_pkg.sv ***
/*
 * smr_pkg: register indices, field layouts, reset values and bus state
 * encoding for the system-management runtime register slice.
 * Assumes a 32-bit AXI4-Lite bus; register index = byte address / 4.
 */
package smr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int          AXI_ADDR_W   = 8;
   localparam int          AXI_DATA_W   = 32;
   localparam int          IDX_W        = 6;
   localparam int          IDX_LSB      = 2;

   ////////////////////////////////////////////////////////////////////////////
   // register indices (byte address = index * 4)
   localparam logic [5:0]  IDX_EN2      = 6'h17;
   localparam logic [5:0]  IDX_EN5      = 6'h1a;
   localparam logic [5:0]  IDX_RSV_A    = 6'h1b;
   localparam logic [5:0]  IDX_STS      = 6'h1c;
   localparam logic [5:0]  IDX_RSV_B    = 6'h1d;
   localparam logic [5:0]  IDX_FORCE    = 6'h1e;
   localparam logic [5:0]  IDX_MASK     = 6'h30;

   ////////////////////////////////////////////////////////////////////////////
   // fields and reset values
   localparam int          REG_W        = 8;
   localparam int          STS_W        = 6;
   localparam int          FORCE_W      = 2;
   localparam int          ROUTE_BIT    = 7;
   localparam logic [7:0]  EN5_RST      = 8'h00;
   localparam logic [7:0]  EN5_WMASK    = 8'hcf;
   localparam logic [0:0]  ROUTE_RST    = 1'h0;
   localparam logic [5:0]  STS_RST      = 6'h00;
   localparam logic [5:0]  MASK_RST     = 6'h00;
   localparam logic [1:0]  FORCE_RST    = 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // responses and bus states
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_RLOAD = 2'b01,
      ST_RRESP = 2'b11,
      ST_WRESP = 2'b10
   } smr_bus_state_t;

endpackage

// *** verilog/smr_edge_det.sv ***
/*
 * smr_edge_det: two-flop synchroniser plus either-edge detector per bit.
 * Assumes one clock; edge_o is a one-cycle pulse per sampled change.
 */
`timescale 1ns/1ps
module smr_edge_det
#(
   parameter int W = 6
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] pins_i,
   output logic      [W-1:0] edge_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;
   logic [2:0]   primed_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_next;
   logic [W-1:0] prev_next;
   logic [2:0]   primed_next;

   always_comb
   begin
      meta_next   = pins_i;
      sync_next   = meta_reg;
      prev_next   = sync_reg;
      primed_next = {primed_reg[1:0], 1'b1};
      // prev is a real sample only three edges after reset
      edge_o      = primed_reg[2] ? (sync_reg ^ prev_reg) : '0;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         meta_reg   <= '0;
         sync_reg   <= '0;
         prev_reg   <= '0;
         primed_reg <= '0;
      end
      else
      begin
         meta_reg   <= meta_next;
         sync_reg   <= sync_next;
         prev_reg   <= prev_next;
         primed_reg <= primed_next;
      end
   end

endmodule

// *** verilog/smr_axil_slave.sv ***
/*
 * smr_axil_slave: AXI4-Lite slave front end, one access at a time.
 * Assumes the register file answers rd_data/rd_ok/wr_ok combinationally.
 */
`timescale 1ns/1ps
module smr_axil_slave
   import smr_pkg::*;
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        awvalid_i,
   output logic                             awready_o,
   input  wire logic [smr_pkg::AXI_ADDR_W-1:0] awaddr_i,
   input  wire logic                        wvalid_i,
   output logic                             wready_o,
   input  wire logic [smr_pkg::AXI_DATA_W-1:0] wdata_i,
   input  wire logic [3:0]                  wstrb_i,
   output logic                             bvalid_o,
   input  wire logic                        bready_i,
   output logic [1:0]                       bresp_o,
   input  wire logic                        arvalid_i,
   output logic                             arready_o,
   input  wire logic [smr_pkg::AXI_ADDR_W-1:0] araddr_i,
   output logic                             rvalid_o,
   input  wire logic                        rready_i,
   output logic [smr_pkg::AXI_DATA_W-1:0]   rdata_o,
   output logic [1:0]                       rresp_o,
   output logic                             wr_en_o,
   output logic [smr_pkg::IDX_W-1:0]        wr_idx_o,
   output logic [smr_pkg::REG_W-1:0]        wr_data_o,
   input  wire logic                        wr_ok_i,
   output logic [smr_pkg::IDX_W-1:0]        rd_idx_o,
   input  wire logic [smr_pkg::REG_W-1:0]   rd_data_i,
   input  wire logic                        rd_ok_i
);
   import smr_pkg::*;

   smr_bus_state_t        state_reg, state_next;
   logic                  aw_got_reg, aw_got_next, w_got_reg, w_got_next;
   logic                  awready_reg, awready_next, wready_reg, wready_next;
   logic                  arready_reg, arready_next;
   logic                  bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0]            bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [IDX_W-1:0]      waddr_reg, waddr_next, raddr_reg, raddr_next;
   logic [REG_W-1:0]      wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic                  wlane_reg, wlane_next;
   logic                  aw_take, w_take, ar_take, wr_demand, idle;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      aw_take      = awvalid_i & awready_reg;
      w_take       = wvalid_i & wready_reg;
      ar_take      = arvalid_i & arready_reg;
      idle         = (state_reg == ST_IDLE);
      wr_demand    = awvalid_i | wvalid_i | aw_got_reg | w_got_reg;
      state_next   = state_reg;
      aw_got_next  = aw_got_reg | aw_take;
      w_got_next   = w_got_reg | w_take;
      waddr_next   = aw_take ? awaddr_i[IDX_LSB +: IDX_W] : waddr_reg;
      wdata_next   = w_take ? wdata_i[REG_W-1:0] : wdata_reg;
      wlane_next   = w_take ? wstrb_i[0] : wlane_reg;
      raddr_next   = ar_take ? araddr_i[IDX_LSB +: IDX_W] : raddr_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      // reads offered only with no write pending
      awready_next = idle & wr_demand & ~aw_got_reg & ~aw_take & ~ar_take;
      wready_next  = idle & wr_demand & ~w_got_reg & ~w_take & ~ar_take;
      arready_next = idle & ~wr_demand & ~ar_take;
      // only lane 0 holds bits
      wr_en_o      = idle & aw_got_reg & w_got_reg & wlane_reg;
      wr_idx_o     = waddr_reg;
      wr_data_o    = wdata_reg;
      rd_idx_o     = raddr_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (aw_got_reg && w_got_reg)
            begin
               aw_got_next  = 1'b0;
               w_got_next   = 1'b0;
               bvalid_next  = 1'b1;
               bresp_next   = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
               state_next   = ST_WRESP;
            end
            else if (ar_take)
               state_next = ST_RLOAD;
         end
         ST_RLOAD:
         begin
            rdata_next  = rd_data_i;
            rresp_next  = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
            rvalid_next = 1'b1;
            state_next  = ST_RRESP;
         end
         ST_RRESP:
         begin
            if (rready_i)
            begin
               rvalid_next = 1'b0;
               state_next  = ST_IDLE;
            end
         end
         ST_WRESP:
         begin
            if (bready_i)
            begin
               bvalid_next = 1'b0;
               state_next  = ST_IDLE;
            end
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg   <= ST_IDLE;
         aw_got_reg  <= 1'b0;
         w_got_reg   <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         arready_reg <= 1'b0;
         bvalid_reg  <= 1'b0;
         rvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rresp_reg   <= RESP_OKAY;
         waddr_reg   <= '0;
         wdata_reg   <= '0;
         wlane_reg   <= 1'b0;
         raddr_reg   <= '0;
         rdata_reg   <= '0;
      end
      else
      begin
         state_reg   <= state_next;
         aw_got_reg  <= aw_got_next;
         w_got_reg   <= w_got_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         arready_reg <= arready_next;
         bvalid_reg  <= bvalid_next;
         rvalid_reg  <= rvalid_next;
         bresp_reg   <= bresp_next;
         rresp_reg   <= rresp_next;
         waddr_reg   <= waddr_next;
         wdata_reg   <= wdata_next;
         wlane_reg   <= wlane_next;
         raddr_reg   <= raddr_next;
         rdata_reg   <= rdata_next;
      end
   end

   assign awready_o = awready_reg;
   assign wready_o  = wready_reg;
   assign arready_o = arready_reg;
   assign bvalid_o  = bvalid_reg;
   assign bresp_o   = bresp_reg;
   assign rvalid_o  = rvalid_reg;
   assign rresp_o   = rresp_reg;
   assign rdata_o   = {{(AXI_DATA_W-REG_W){1'b0}}, rdata_reg};

endmodule

// *** verilog/smr_regs.sv ***
/*
 * smr_regs: interrupt enable, either-edge status and disk-change override
 * registers behind an AXI4-Lite slave.
 * Assumes pins synchronous to clk_i; rst_n_i is the standby-rail reset,
 * main_rst_n_i the main-supply reset; both synchronous, active low.
 */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - enable five bits gate sources onto group irq
// - enable bits 4,5 and 0x1b,0x1d read zero
// - either edge on six pins sets status bits
// - writing one clears status bit, zero ignored
// - status bits 7 and 6 read zero
// - override bits software settable, not software clearable
// - step with drive select clears that override
// - disk-changed flag combines selects, overrides, input
// - override resets to 0x01 on main reset
// - group irq reaches pin only when routed
module smr_regs
   import smr_pkg::*;
(
   input  wire logic                           clk_i,
   input  wire logic                           rst_n_i,
   input  wire logic                           main_rst_n_i,
   input  wire logic                           s_axi_awvalid_i,
   output logic                                s_axi_awready_o,
   input  wire logic [smr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic                           s_axi_wvalid_i,
   output logic                                s_axi_wready_o,
   input  wire logic [smr_pkg::AXI_DATA_W-1:0] s_axi_wdata_i,
   input  wire logic [3:0]                     s_axi_wstrb_i,
   output logic                                s_axi_bvalid_o,
   input  wire logic                           s_axi_bready_i,
   output logic [1:0]                          s_axi_bresp_o,
   input  wire logic                           s_axi_arvalid_i,
   output logic                                s_axi_arready_o,
   input  wire logic [smr_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
   output logic                                s_axi_rvalid_o,
   input  wire logic                           s_axi_rready_i,
   output logic [smr_pkg::AXI_DATA_W-1:0]      s_axi_rdata_o,
   output logic [1:0]                          s_axi_rresp_o,
   input  wire logic                           gpio_5_4_i,
   input  wire logic                           gpio_5_5_i,
   input  wire logic                           gpio_5_6_i,
   input  wire logic                           gpio_5_7_i,
   input  wire logic                           fan_speed_input_one_i,
   input  wire logic                           fan_speed_input_two_i,
   input  wire logic                           gpio_2_1_i,
   input  wire logic                           gpio_2_2_i,
   input  wire logic                           gpio_4_1_i,
   input  wire logic                           gpio_4_3_i,
   input  wire logic                           gpio_6_0_i,
   input  wire logic                           gpio_6_1_i,
   input  wire logic                           head_step_n_i,
   input  wire logic                           drive_select_zero_n_i,
   input  wire logic                           drive_select_one_n_i,
   input  wire logic                           disk_changed_input_n_i,
   output logic                                grouped_mgmt_irq_n_o,
   output logic                                mgmt_irq_pin_n_o,
   output logic                                disk_changed_flag_o,
   output logic                                irq_o
);
   import smr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // bus front end

   logic                wr_en;
   logic [IDX_W-1:0]    wr_idx;
   logic [REG_W-1:0]    wr_data;
   logic                wr_ok;
   logic [IDX_W-1:0]    rd_idx;
   logic [REG_W-1:0]    rd_data;
   logic                rd_ok;

   smr_axil_slave u_bus
   (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .awvalid_i (s_axi_awvalid_i),
      .awready_o (s_axi_awready_o),
      .awaddr_i  (s_axi_awaddr_i),
      .wvalid_i  (s_axi_wvalid_i),
      .wready_o  (s_axi_wready_o),
      .wdata_i   (s_axi_wdata_i),
      .wstrb_i   (s_axi_wstrb_i),
      .bvalid_o  (s_axi_bvalid_o),
      .bready_i  (s_axi_bready_i),
      .bresp_o   (s_axi_bresp_o),
      .arvalid_i (s_axi_arvalid_i),
      .arready_o (s_axi_arready_o),
      .araddr_i  (s_axi_araddr_i),
      .rvalid_o  (s_axi_rvalid_o),
      .rready_i  (s_axi_rready_i),
      .rdata_o   (s_axi_rdata_o),
      .rresp_o   (s_axi_rresp_o),
      .wr_en_o   (wr_en),
      .wr_idx_o  (wr_idx),
      .wr_data_o (wr_data),
      .wr_ok_i   (wr_ok),
      .rd_idx_o  (rd_idx),
      .rd_data_i (rd_data),
      .rd_ok_i   (rd_ok)
   );

   ////////////////////////////////////////////////////////////////////////////
   // edge capture on the six status pins

   logic [STS_W-1:0]    edge_pins;
   logic [STS_W-1:0]    edge_hit;

   // bit order follows the status register layout
   assign edge_pins = {gpio_6_1_i, gpio_6_0_i, gpio_4_3_i,
                       gpio_4_1_i, gpio_2_2_i, gpio_2_1_i};

   smr_edge_det #(.W(STS_W)) u_edge
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .pins_i  (edge_pins),
      .edge_o  (edge_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   logic                hit_en2;
   logic                hit_en5;
   logic                hit_sts;
   logic                hit_force;
   logic                hit_mask;
   logic                hit_rsv;

   always_comb
   begin
      hit_en2   = (wr_idx == IDX_EN2);
      hit_en5   = (wr_idx == IDX_EN5);
      hit_sts   = (wr_idx == IDX_STS);
      hit_force = (wr_idx == IDX_FORCE);
      hit_mask  = (wr_idx == IDX_MASK);
      hit_rsv   = (wr_idx == IDX_RSV_A) | (wr_idx == IDX_RSV_B);
      // reserved words accept and drop writes; anything else is an error
      wr_ok     = hit_en2 | hit_en5 | hit_sts | hit_force | hit_mask | hit_rsv;
   end

   ////////////////////////////////////////////////////////////////////////////
   // standby-rail registers

   logic [REG_W-1:0]    en5_reg, en5_next;
   logic                route_reg, route_next;
   logic [STS_W-1:0]    sts_reg, sts_next;
   logic [STS_W-1:0]    mask_reg, mask_next;
   logic [STS_W-1:0]    sts_clr;

   always_comb
   begin
      en5_next   = en5_reg;
      route_next = route_reg;
      mask_next  = mask_reg;
      sts_clr    = '0;
      if (wr_en && hit_en5)
         en5_next = wr_data & EN5_WMASK;
      if (wr_en && hit_en2)
         route_next = wr_data[ROUTE_BIT];
      if (wr_en && hit_mask)
         mask_next = wr_data[STS_W-1:0];
      if (wr_en && hit_sts)
         sts_clr = wr_data[STS_W-1:0];
      // a fresh edge in the clearing cycle survives the clear
      sts_next = (sts_reg & ~sts_clr) | edge_hit;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         en5_reg   <= EN5_RST;
         route_reg <= ROUTE_RST;
         sts_reg   <= STS_RST;
         mask_reg  <= MASK_RST;
      end
      else
      begin
         en5_reg   <= en5_next;
         route_reg <= route_next;
         sts_reg   <= sts_next;
         mask_reg  <= mask_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main-supply disk-change override

   logic [FORCE_W-1:0]  force_reg, force_next;
   logic [FORCE_W-1:0]  force_set;
   logic [FORCE_W-1:0]  force_hw_clr;
   logic [FORCE_W-1:0]  drive_sel;
   logic                step_on;

   always_comb
   begin
      drive_sel    = {~drive_select_one_n_i, ~drive_select_zero_n_i};
      step_on      = ~head_step_n_i;
      force_hw_clr = drive_sel & {FORCE_W{step_on}};
      force_set    = (wr_en && hit_force) ? wr_data[FORCE_W-1:0] : '0;
      // zeros written are ignored; a software set beats a same-cycle step
      force_next   = (force_reg & ~force_hw_clr) | force_set;
   end

   always_ff @(posedge clk_i)
   begin
      if (!main_rst_n_i)
         force_reg <= FORCE_RST;
      else
         force_reg <= force_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux

   always_comb
   begin
      rd_data = '0;
      rd_ok   = 1'b1;
      case (rd_idx)
         IDX_EN2:   rd_data[ROUTE_BIT] = route_reg;
         IDX_EN5:   rd_data = en5_reg;
         IDX_STS:   rd_data[STS_W-1:0] = sts_reg;
         IDX_FORCE: rd_data[FORCE_W-1:0] = force_reg;
         IDX_MASK:  rd_data[STS_W-1:0] = mask_reg;
         IDX_RSV_A: rd_data = '0;
         IDX_RSV_B: rd_data = '0;
         default:   rd_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all registered

   logic [REG_W-1:0]    src_vec;
   logic                grp_n_reg, grp_n_next;
   logic                pin_n_reg, pin_n_next;
   logic                dchg_reg, dchg_next;
   logic                irq_reg, irq_next;

   always_comb
   begin
      // pin levels stand for pending requests; bits 4,5 carry none
      src_vec    = {fan_speed_input_two_i, fan_speed_input_one_i, 2'b00,
                    gpio_5_7_i, gpio_5_6_i, gpio_5_5_i, gpio_5_4_i};
      grp_n_next = ~|(src_vec & en5_reg);
      // routed copy lags the group level a cycle
      pin_n_next = route_reg ? grp_n_reg : 1'b1;
      dchg_next  = |(drive_sel & force_reg) | ~disk_changed_input_n_i;
      irq_next   = |(sts_reg & mask_reg);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         grp_n_reg <= 1'b1;
         pin_n_reg <= 1'b1;
         dchg_reg  <= 1'b0;
         irq_reg   <= 1'b0;
      end
      else
      begin
         grp_n_reg <= grp_n_next;
         pin_n_reg <= pin_n_next;
         dchg_reg  <= dchg_next;
         irq_reg   <= irq_next;
      end
   end

   assign grouped_mgmt_irq_n_o = grp_n_reg;
   assign mgmt_irq_pin_n_o     = pin_n_reg;
   assign disk_changed_flag_o  = dchg_reg;
   assign irq_o                = irq_reg;

endmodule

// *** tb/smr_regs_sva.sv ***
/* smr_regs_sva: port-level checks on smr_regs.
   assumes one clock domain; bound at the foot. */
`timescale 1ns/1ps
module smr_regs_sva
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        s_axi_awvalid_i,
   input  wire logic        s_axi_awready_o,
   input  wire logic        s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [1:0]  s_axi_bresp_o,
   input  wire logic        s_axi_arvalid_i,
   input  wire logic        s_axi_arready_o,
   input  wire logic        s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic [31:0] s_axi_rdata_o,
   input  wire logic        gpio_5_4_i,
   input  wire logic        gpio_5_5_i,
   input  wire logic        gpio_5_6_i,
   input  wire logic        gpio_5_7_i,
   input  wire logic        fan_speed_input_one_i,
   input  wire logic        fan_speed_input_two_i,
   input  wire logic        disk_changed_input_n_i,
   input  wire logic        disk_changed_flag_o,
   input  wire logic        grouped_mgmt_irq_n_o,
   input  wire logic        mgmt_irq_pin_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic [5:0] src = {fan_speed_input_two_i, fan_speed_input_one_i,
                           gpio_5_7_i, gpio_5_6_i, gpio_5_5_i, gpio_5_4_i};
   ////////////////////////////////////////////////////////////////////////////
   sequence s_ar_take;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   sequence s_rd_ans;
      ##2 s_axi_rvalid_o;
   endsequence
   a_read_latency: assert property (s_ar_take |-> s_rd_ans) else $error("read answer late");
   a_write_latency: assert property (s_axi_awvalid_i && s_axi_awready_o |-> ##[2:8] s_axi_bvalid_o)
      else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped");
   a_one_access: assert property (!(s_axi_arready_o && s_axi_awready_o)) else $error("read and write both ready");
   a_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   a_group_quiet: assert property (src == 6'h00 |=> grouped_mgmt_irq_n_o)
      else $error("group irq without source");
   a_route_follow: assert property (grouped_mgmt_irq_n_o |=> mgmt_irq_pin_n_o)
      else $error("pin irq without group irq");
   a_flag_input: assert property (!disk_changed_input_n_i |=> disk_changed_flag_o)
      else $error("disk change flag missed input");
endmodule

bind smr_regs smr_regs_sva u_smr_regs_sva (.*);

// *** tb/smr_pin_model.sv ***
/* smr_pin_model: pin and floppy drive levels facing the slice.
   assumes the bench calls drive() between bus accesses. */
`timescale 1ns/1ps
module smr_pin_model
(
   input  wire logic        clk_i,
   output logic      [15:0] pins_o
);
   // drive lines idle high (deselected), all pins low
   initial pins_o = 16'hf000;
   task automatic drive(input logic [15:0] v);
      @(posedge clk_i);
      pins_o <= v;
   endtask
endmodule

// *** tb/testbench.sv ***
/* testbench: register, pin and floppy checks on smr_regs.
   assumes smr_pkg compiled first; pins come from smr_pin_model. */
`timescale 1ns/1ps
module testbench;
   import smr_pkg::*;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, main_rst_n_i = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd;
   logic        awr, wrd, bv, arr, rv, grp_n, pin_n, flag, irq;
   logic [1:0]  br, rr;
   logic [15:0] pins;
   int          num_errors = 0, compares = 0, cyc = 0;
   smr_pin_model u_smr_pin_model (.clk_i(clk_i), .pins_o(pins));
   smr_regs u_smr_regs
   (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .main_rst_n_i(main_rst_n_i),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bre), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .s_axi_rdata_o(rd),
      .s_axi_rresp_o(rr), .gpio_5_4_i(pins[0]), .gpio_5_5_i(pins[1]), .gpio_5_6_i(pins[2]),
      .gpio_5_7_i(pins[3]), .fan_speed_input_one_i(pins[4]), .fan_speed_input_two_i(pins[5]),
      .gpio_2_1_i(pins[6]), .gpio_2_2_i(pins[7]), .gpio_4_1_i(pins[8]), .gpio_4_3_i(pins[9]),
      .gpio_6_0_i(pins[10]), .gpio_6_1_i(pins[11]), .head_step_n_i(pins[12]),
      .drive_select_zero_n_i(pins[13]), .drive_select_one_n_i(pins[14]),
      .disk_changed_input_n_i(pins[15]), .grouped_mgmt_irq_n_o(grp_n), .mgmt_irq_pin_n_o(pin_n),
      .disk_changed_flag_o(flag), .irq_o(irq)
   );
   initial forever #2 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // address and data offered together, each dropped when taken
   task automatic reg_wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      logic ta = 1'b0, tw = 1'b0;
      @(posedge clk_i);
      awv <= 1'b1; awa <= {i, 2'b00}; wv <= 1'b1; wd <= {24'h0, d}; bre <= 1'b1;
      while (!(ta && tw))
      begin
         @(posedge clk_i);
         if (awr === 1'b1) awv <= 1'b0;
         if (wrd === 1'b1) wv <= 1'b0;
         ta = ta | (awr === 1'b1);
         tw = tw | (wrd === 1'b1);
      end
      do @(posedge clk_i); while (bv !== 1'b1);
      bre <= 1'b0;
      chk("bresp", 32'(br), 32'(er));
      @(posedge clk_i);
   endtask
   task automatic reg_chk(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
      @(posedge clk_i);
      arv <= 1'b1; ara <= {i, 2'b00}; rre <= 1'b1;
      do @(posedge clk_i); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk_i); while (rv !== 1'b1);
      rre <= 1'b0;
      chk("rdata", rd, {24'h0, e});
      chk("rresp", 32'(rr), 32'(er));
   endtask
   // covers synchroniser, compare and status flop latency
   task automatic pin(input logic [15:0] v);
      u_smr_pin_model.drive(v);
      repeat (6) @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      main_rst_n_i <= 1'b1;
      reg_chk(IDX_EN5, 8'h00);
      reg_chk(IDX_STS, 8'h00);
      reg_chk(IDX_FORCE, 8'h01);
      reg_chk(IDX_EN2, 8'h00);
      reg_wr(IDX_RSV_A, 8'hff);
      reg_chk(IDX_RSV_A, 8'h00);
      reg_wr(IDX_RSV_B, 8'hff);
      reg_chk(IDX_RSV_B, 8'h00);
      reg_wr(IDX_EN5, 8'hff);
      reg_chk(IDX_EN5, 8'hcf);
      reg_wr(6'h3f, 8'hff, RESP_SLVERR);
      reg_chk(6'h3f, 8'h00, RESP_SLVERR);
      $display("test registers done");
      reg_wr(IDX_EN2, 8'h80);
      for (int k = 0; k < 6; k++)
      begin
         pin(16'hf000 | (16'h1 << k));
         chk("grouped", 32'(grp_n), 32'h0);
         chk("irq pin", 32'(pin_n), 32'h0);
      end
      reg_wr(IDX_EN2, 8'h00);
      chk("irq pin", 32'(pin_n), 32'h1);
      reg_wr(IDX_EN5, 8'h00);
      pin(16'hf03f);
      chk("grouped", 32'(grp_n), 32'h1);
      $display("test grouped irq done");
      reg_wr(IDX_MASK, 8'h3f);
      for (int k = 0; k < 6; k++)
      begin
         pin(16'hf000 | (16'h40 << k));
         reg_chk(IDX_STS, 8'((2 << k) - 1));
      end
      chk("irq", 32'(irq), 32'h1);
      reg_wr(IDX_STS, 8'h05);
      reg_chk(IDX_STS, 8'h3a);
      reg_wr(IDX_STS, 8'hff);
      reg_chk(IDX_STS, 8'h00);
      chk("irq", 32'(irq), 32'h0);
      pin(16'hf000);
      reg_chk(IDX_STS, 8'h20);
      reg_wr(IDX_MASK, 8'h00);
      chk("irq", 32'(irq), 32'h0);
      reg_wr(IDX_STS, 8'h20);
      $display("test edge status done");
      reg_wr(IDX_FORCE, 8'h00);
      reg_chk(IDX_FORCE, 8'h01);
      reg_wr(IDX_FORCE, 8'h02);
      reg_chk(IDX_FORCE, 8'h03);
      pin(16'hb000);
      chk("flag", 32'(flag), 32'h1);
      pin(16'hc000);
      reg_chk(IDX_FORCE, 8'h02);
      pin(16'hd000);
      chk("flag", 32'(flag), 32'h0);
      pin(16'h7000);
      chk("flag", 32'(flag), 32'h1);
      pin(16'ha000);
      reg_chk(IDX_FORCE, 8'h00);
      main_rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      main_rst_n_i <= 1'b1;
      reg_chk(IDX_FORCE, 8'h01);
      $display("test disk change done");
      give_verdict();
   end
   // whole run is near 300 cycles
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc > 6000)
      begin
         num_errors++;
         give_verdict();
      end
   end
endmodule
